/* bench/light_inspection_override_regs_tb.sv */
/*
  self-checking bench for the inspection and override register bank.
  assumes hw/ on the include path; a second is shortened to CPS cycles.
*/
`timescale 1ns/1ns
`include "lio_regs_defs.vh"

module light_inspection_override_regs_tb;
  localparam int CPS = 20;
  logic ref_clk, rst_n, insp_running, insp_start, insp_done, ok, rj;
  logic [3:0] insp_stage_code;
  logic [7:0] insp_result_flags;
  logic [15:0] rv;
  wire reg_rd, reg_wr, rd_valid_q, wr_done_q, wr_reject_q, insp_ready_q, ovr_active_q;
  wire [7:0] reg_addr;
  wire [15:0] reg_wdata, rd_data_q, dwell_seconds_q, ovr_mode_q;
  int miscompares = 0;
  int comparisons = 0;
  int up_cyc = 0;

  lio_regs #(.CYC_PER_SEC(CPS)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
    .wr_done_q(wr_done_q), .wr_reject_q(wr_reject_q), .insp_running(insp_running),
    .insp_stage_code(insp_stage_code), .insp_start(insp_start), .insp_done(insp_done),
    .insp_result_flags(insp_result_flags), .dwell_seconds_q(dwell_seconds_q), .insp_ready_q(insp_ready_q),
    .ovr_active_q(ovr_active_q), .ovr_mode_q(ovr_mode_q));
  lio_master_model mstr_u (.ref_clk(ref_clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .wr_done_q(wr_done_q),
    .wr_reject_q(wr_reject_q));

  // ----------------------------------------------------------------------
  // clock, uptime reference, helpers
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) up_cyc <= rst_n ? up_cyc + 1 : 0;
  task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    mstr_u.rd_word(a, rv, ok);
    chk16("read valid", 16'h0001, {15'h0000, ok});
    chk16($sformatf("register %h", a), exp, rv);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [15:0] d, input logic rej);
    mstr_u.wr_word(a, d, ok, rj);
    chk16($sformatf("write answer %h", a), {14'h0000, 1'b1, rej}, {14'h0000, ok, rj});
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_vals();
    rd_chk(8'h2c, 16'h001e);
    rd_chk(8'h3c, 16'h0000);
    rd_chk(8'h3d, 16'h003c);
    rd_chk(8'h1e, 16'h0000);
  endtask
  // every stage code, then an illegal code that must not be shown
  task automatic t_stages();
    for (int c = 0; c < 10; c++) begin
      insp_stage_code = c[3:0];
      rd_chk(8'h1f, {12'h000, c[3:0]});
    end
    insp_stage_code = 4'hc;
    rd_chk(8'h1f, 16'h0009);
  endtask
  // one flag at a time; flags flip after the latch to prove it holds
  task automatic t_results();
    for (int i = 0; i < 8; i++) begin
      insp_start = 1'b1;
      insp_running = 1'b1;
      @(negedge ref_clk);
      insp_start = 1'b0;
      rd_chk(8'h1e, 16'h0001);
      chk16("ready out", 16'h0000, {15'h0000, insp_ready_q});
      insp_result_flags = 8'h01 << i;
      insp_done = 1'b1;
      insp_running = 1'b0;
      @(negedge ref_clk);
      insp_done = 1'b0;
      insp_result_flags = ~insp_result_flags;
      rd_chk(8'h20, {8'h01 << i, 8'h00});
      rd_chk(8'h1e, 16'h0008);
      chk16("ready out", 16'h0001, {15'h0000, insp_ready_q});
    end
  endtask
  task automatic t_unused();
    for (int a = 8'h23; a < 8'h2c; a++) rd_chk(a[7:0], 16'hffff);
    wr_chk(8'h24, 16'h1234, 1'b0);
    rd_chk(8'h24, 16'hffff);
  endtask
  task automatic t_dwell();
    wr_chk(8'h2c, 16'h001d, 1'b1);
    wr_chk(8'h2c, 16'h1c20, 1'b0);
    rd_chk(8'h2c, 16'h1c20);
    wr_chk(8'h2c, 16'h1c21, 1'b1);
    wr_chk(8'h2c, 16'h001e, 1'b0);
    chk16("dwell out", 16'h001e, dwell_seconds_q);
  endtask
  // the mode change restarts the minute count, so waits run from there
  task automatic t_override();
    mstr_u.set_override(16'h0001, 16'h0002, rj);
    chk16("override refused", 16'h0000, {15'h0000, rj});
    rd_chk(8'h3c, 16'h0001);
    wr_chk(8'h3c, 16'h0003, 1'b0);
    wr_chk(8'h3c, 16'h0002, 1'b1);
    wr_chk(8'h3d, 16'h0000, 1'b1);
    rd_chk(8'h3c, 16'h0003);
    chk16("mode out", 16'h0003, ovr_mode_q);
    chk16("active out", 16'h0001, {15'h0000, ovr_active_q});
    rd_chk(8'h3d, 16'h0002);
    repeat (60 * CPS) @(negedge ref_clk);
    rd_chk(8'h3d, 16'h0001);
    repeat (60 * CPS) @(negedge ref_clk);
    rd_chk(8'h3c, 16'h0000);
    rd_chk(8'h3d, 16'h0002);
    chk16("active out", 16'h0000, {15'h0000, ovr_active_q});
    mstr_u.set_override(16'h0003, 16'hffff, rj);
    chk16("override refused", 16'h0000, {15'h0000, rj});
    rd_chk(8'h3d, 16'hffff);
    wr_chk(8'h3c, 16'h0004, 1'b0);
    rd_chk(8'h3c, 16'h0000);
    rd_chk(8'h3d, 16'hffff);
  endtask
  // tick phase is free running, so allow one second either way
  task automatic t_age();
    int s;
    int t;
    s = up_cyc / CPS;
    rd_chk(8'h21, 16'h0000);
    mstr_u.rd_word(8'h22, rv, ok);
    t = rv[15:8] * 60 + rv[7:0];
    chk16("age seconds", 16'h0001, {15'h0000, ok && rv[7:0] < 60 && t + 1 >= s && t <= s + 1});
  endtask
  // ----------------------------------------------------------------------
  // sequence, watchdog, verdict
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    insp_running = 1'b0;
    insp_start = 1'b0;
    insp_done = 1'b0;
    insp_stage_code = 4'h0;
    insp_result_flags = 8'h00;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset_vals();
    t_stages();
    t_results();
    t_unused();
    t_dwell();
    t_override();
    t_age();
    tally_and_finish();
  end
  // the run needs about 2600 cycles; nearly four times that means a hang
  initial begin
    repeat (10000) @(posedge ref_clk);
    miscompares++;
    $display("MISMATCH watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule // light_inspection_override_regs_tb

bind lio_regs lio_regs_chk #(.CYC_PER_SEC(CYC_PER_SEC)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_data_q(rd_data_q),
  .wr_reject_q(wr_reject_q), .insp_stage_code(insp_stage_code), .insp_done(insp_done),
  .insp_result_flags(insp_result_flags), .dwell_seconds_q(dwell_seconds_q), .insp_ready_q(insp_ready_q),
  .ovr_active_q(ovr_active_q), .ovr_mode_q(ovr_mode_q));

/* bench/lio_master_model.sv */
/*
  stand-in for the serial protocol engine: one register word per strobe.
  assumes ref_clk of the bank; strobes change on falling edges only.
*/
`timescale 1ns/1ns

module lio_master_model (
  input wire ref_clk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire rd_valid_q,
  input wire [15:0] rd_data_q,
  input wire wr_done_q,
  input wire wr_reject_q
);
  // idle lines carry the inverse of the last word so nothing stale matches
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // ----------------------------------------------------------------------
  // word accesses: request held across the taking edge, answer one later
  // ----------------------------------------------------------------------
  task automatic wr_word(input logic [7:0] a, input logic [15:0] d, output logic done, output logic rej);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    done = wr_done_q;
    rej = wr_reject_q;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd_word(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    ok = rd_valid_q;
    d = rd_data_q;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
  // mode first, then minutes, so the override is armed before it is timed
  task automatic set_override(input logic [15:0] mode, input logic [15:0] mins, output logic rej);
    logic d1, r1, d2, r2;
    wr_word(8'h3c, mode, d1, r1);
    wr_word(8'h3d, mins, d2, r2);
    rej = r1 | r2 | !d1 | !d2;
  endtask
endmodule // lio_master_model

/* bench/lio_regs_properties.sv */
/*
  concurrent checks on the inspection and override register bank.
  assumes it is bound to lio_regs and sees only that module's ports.
*/
`timescale 1ns/1ns
`include "lio_regs_defs.vh"

module lio_regs_chk #(
  parameter CYC_PER_SEC = 20
) (
  input wire ref_clk,
  input wire rst_n,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] rd_data_q,
  input wire wr_reject_q,
  input wire [3:0] insp_stage_code,
  input wire insp_done,
  input wire [7:0] insp_result_flags,
  input wire [15:0] dwell_seconds_q,
  input wire insp_ready_q,
  input wire ovr_active_q,
  input wire [15:0] ovr_mode_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a read only counts when no write shares its edge
  wire rd_go = reg_rd && !reg_wr;
  wire wr_go = reg_wr;
  wire dw_ok = reg_wdata >= `LIO_DWELL_MIN && reg_wdata <= `LIO_DWELL_MAX;
  // ----------------------------------------------------------------------
  // sequence shapes
  // ----------------------------------------------------------------------
  // the results are read two edges after completion, with the flags moved
  sequence done_then_read;
    insp_done ##1 !insp_done ##1 (!insp_done && rd_go && reg_addr == 8'h20);
  endsequence
  sequence dwell_write;
    wr_go && reg_addr == 8'h2c;
  endsequence
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_stage_echo: assert property (
    rd_go && reg_addr == 8'h1f && $past(rst_n) && $past(insp_stage_code) <= 4'h9
    |=> rd_data_q == {12'h000, $past(insp_stage_code, 2)}) else $error("stage read wrong");
  chk_result_word: assert property (
    done_then_read |=> rd_data_q == {$past(insp_result_flags, 3), 8'h00}) else $error("results wrong");
  chk_ready_set: assert property (
    insp_done |=> insp_ready_q) else $error("ready not set");
  chk_unused_ones: assert property (
    rd_go && reg_addr > 8'h22 && reg_addr < 8'h2c |=> rd_data_q == 16'hffff) else $error("unused not ones");
  chk_dwell_range: assert property (
    dwell_seconds_q >= `LIO_DWELL_MIN && dwell_seconds_q <= `LIO_DWELL_MAX) else $error("dwell out of range");
  chk_dwell_take: assert property (
    dwell_write ##0 dw_ok |=> !wr_reject_q && dwell_seconds_q == $past(reg_wdata)) else $error("dwell not taken");
  chk_dwell_refuse: assert property (
    dwell_write ##0 !dw_ok |=> wr_reject_q && $stable(dwell_seconds_q)) else $error("bad dwell kept");
  chk_mode_codes: assert property (
    ovr_active_q ? (ovr_mode_q == 16'h0001 || ovr_mode_q == 16'h0003) : ovr_mode_q == 16'h0000)
    else $error("mode code illegal");
  chk_mode_take: assert property (
    wr_go && reg_addr == 8'h3c && (reg_wdata == 16'h0001 || reg_wdata == 16'h0003)
    |=> ovr_active_q && ovr_mode_q == $past(reg_wdata)) else $error("mode not taken");
  chk_mode_cancel: assert property (
    wr_go && reg_addr == 8'h3c && reg_wdata == 16'h0004 |=> !ovr_active_q && ovr_mode_q == 16'h0000)
    else $error("cancel ignored");
endmodule // lio_regs_chk

/* hw/lio_regs.v */
/*
  register bank for automatic lighting inspection and temporary mode
  override, reached over a word register port driven by the serial
  protocol engine. assumes the engine presents one access per strobe,
  synchronous to ref_clk, and that the inspection sequencer drives the
  stage code and result flags.
*/
`timescale 1ns/1ns
`include "lio_regs_defs.vh"

module lio_regs #(
  parameter CYC_PER_SEC = `LIO_CLK_HZ * `LIO_SEC_IN_SEC
) (
  input wire ref_clk,
  input wire rst_n,
  // register port from the protocol engine
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg rd_valid_q,
  output reg [15:0] rd_data_q,
  output reg wr_done_q,
  output reg wr_reject_q,
  // inspection sequencer
  input wire insp_running,
  input wire [3:0] insp_stage_code,
  input wire insp_start,
  input wire insp_done,
  input wire [7:0] insp_result_flags,
  output reg [15:0] dwell_seconds_q,
  output reg insp_ready_q,
  // override to the lighting mode logic
  output reg ovr_active_q,
  output reg [15:0] ovr_mode_q
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam [2:0] OVR_OFF = 3'b001;
  localparam [2:0] OVR_DAY = 3'b010;
  localparam [2:0] OVR_NIGHT = 3'b100;
  localparam RES_W = 16 - `LIO_RES_LSB;

  reg [2:0] ovr_state_q;
  reg [2:0] ovr_state_d;
  reg [15:0] ovr_set_q;
  reg [15:0] ovr_left_q;
  reg [15:0] ovr_left_d;
  reg [5:0] ovr_sec_q;
  reg [5:0] ovr_sec_d;
  reg [3:0] stage_q;
  reg [RES_W-1:0] results_q;
  reg running_q;
  reg [15:0] rdata_d;
  reg reject_d;

  wire sec_tick;
  wire [7:0] up_sec;
  wire [7:0] up_min;
  wire [7:0] up_hour;
  wire [7:0] up_day;
  wire wr_dwell;
  wire wr_mode;
  wire wr_time;
  wire dwell_ok;
  wire mode_ok;
  wire time_ok;
  wire min_tick;
  wire [15:0] ctrl_word;
  wire [15:0] stage_word;
  wire [15:0] results_word;
  wire [15:0] age_dh_word;
  wire [15:0] age_ms_word;
  wire [15:0] time_word;
  genvar gi;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // mode codes are checked here for write legality only; the start decode compares reg_wdata directly
  function is_start_mode;
    input [15:0] v;
    begin
      is_start_mode = (v == `LIO_MODE_DAY) || (v == `LIO_MODE_NIGHT);
    end
  endfunction

  function [15:0] mode_code;
    input [2:0] st;
    begin
      if (st == OVR_DAY)
        mode_code = `LIO_MODE_DAY;
      else if (st == OVR_NIGHT)
        mode_code = `LIO_MODE_NIGHT;
      else
        mode_code = `LIO_MODE_OFF;
    end
  endfunction

  // ----------------------------------------------------------------------
  // time since power up
  // ----------------------------------------------------------------------
  lio_uptime #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_uptime (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sec_tick_q(sec_tick),
    .sec_q(up_sec),
    .min_q(up_min),
    .hour_q(up_hour),
    .day_q(up_day)
  );

  // ----------------------------------------------------------------------
  // write decode and range checks
  // ----------------------------------------------------------------------
  // writes to read only or unused words are dropped silently
  assign wr_dwell = reg_wr && (reg_addr == `LIO_ADDR_DWELL);
  assign wr_mode = reg_wr && (reg_addr == `LIO_ADDR_OVR_MODE);
  assign wr_time = reg_wr && (reg_addr == `LIO_ADDR_OVR_TIME);
  assign dwell_ok = (reg_wdata >= `LIO_DWELL_MIN) && (reg_wdata <= `LIO_DWELL_MAX);
  assign mode_ok = is_start_mode(reg_wdata) || (reg_wdata == `LIO_MODE_CANCEL);
  assign time_ok = (reg_wdata >= `LIO_OVR_TIME_MIN);
  assign min_tick = sec_tick && (ovr_sec_q == `LIO_SEC_PER_MIN);

  // reject flag for the engine, which answers with an argument exception
  always @* begin
    reject_d = 1'b0;
    if (wr_dwell && !dwell_ok)
      reject_d = 1'b1;
    else if (wr_mode && !mode_ok)
      reject_d = 1'b1;
    else if (wr_time && !time_ok)
      reject_d = 1'b1;
  end

  // ----------------------------------------------------------------------
  // stage dwell register
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      dwell_seconds_q <= `LIO_DWELL_RST;
    end else if (wr_dwell && dwell_ok) begin
      dwell_seconds_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // inspection stage, results and completion
  // ----------------------------------------------------------------------
  // codes past the last stage are held off so software never sees junk
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      stage_q <= 4'h0;
      running_q <= 1'b0;
      insp_ready_q <= 1'b0;
    end else begin
      running_q <= insp_running;
      if (insp_stage_code <= `LIO_STAGE_LAST)
        stage_q <= insp_stage_code;
      // completion wins over a start in the same cycle
      if (insp_done) begin
        insp_ready_q <= 1'b1;
      end else if (insp_start) begin
        insp_ready_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // result flags
  // ----------------------------------------------------------------------
  // flags are taken only on completion, so a half run never shows a verdict
  generate
    for (gi = 0; gi < RES_W; gi = gi + 1) begin : g_result
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          results_q[gi] <= 1'b0;
        end else if (insp_done) begin
          results_q[gi] <= insp_result_flags[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // override state machine
  // ----------------------------------------------------------------------
  // a mode write from off starts with the stored duration; a following time write
  // reloads the remaining count, so either write order works
  always @* begin
    ovr_state_d = ovr_state_q;
    ovr_left_d = ovr_left_q;
    ovr_sec_d = ovr_sec_q;
    if (ovr_state_q != OVR_OFF && sec_tick)
      ovr_sec_d = min_tick ? 6'h0 : ovr_sec_q + 6'h1;
    case (ovr_state_q)
      OVR_OFF: begin
        ovr_left_d = ovr_set_q;
      end
      OVR_DAY, OVR_NIGHT: begin
        if (min_tick) begin
          ovr_left_d = ovr_left_q - 16'h1;
          if (ovr_left_q == `LIO_OVR_TIME_MIN)
            ovr_state_d = OVR_OFF;
        end
      end
      default: begin
        ovr_state_d = OVR_OFF;
      end
    endcase
    if (wr_time && time_ok && ovr_state_q != OVR_OFF)
      ovr_left_d = reg_wdata;
    if (wr_mode && mode_ok) begin
      if (reg_wdata == `LIO_MODE_CANCEL) begin
        ovr_state_d = OVR_OFF;
      end else begin
        ovr_state_d = (reg_wdata == `LIO_MODE_DAY) ? OVR_DAY : OVR_NIGHT;
        ovr_sec_d = 6'h0;
        if (ovr_state_q == OVR_OFF)
          ovr_left_d = ovr_set_q;
      end
    end
    if (ovr_state_d == OVR_OFF)
      ovr_sec_d = 6'h0;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ovr_state_q <= OVR_OFF;
      ovr_set_q <= `LIO_OVR_TIME_RST;
      ovr_left_q <= `LIO_OVR_TIME_RST;
      ovr_sec_q <= 6'h0;
      ovr_active_q <= 1'b0;
      ovr_mode_q <= `LIO_MODE_OFF;
    end else begin
      ovr_state_q <= ovr_state_d;
      ovr_left_q <= ovr_left_d;
      ovr_sec_q <= ovr_sec_d;
      if (wr_time && time_ok)
        ovr_set_q <= reg_wdata;
      ovr_active_q <= (ovr_state_d != OVR_OFF);
      ovr_mode_q <= mode_code(ovr_state_d);
    end
  end

  // ----------------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------------
  // packed once here so the mux below stays a plain address chain
  assign ctrl_word = ({15'h0000, insp_ready_q} << `LIO_CTRL_READY_BIT)
    | ({15'h0000, running_q} << `LIO_CTRL_RUNNING_BIT);
  assign stage_word = {12'h000, stage_q};
  assign results_word = {results_q, {`LIO_RES_LSB{1'b0}}};
  assign age_dh_word = {up_day, up_hour};
  assign age_ms_word = {up_min, up_sec};
  assign time_word = (ovr_state_q != OVR_OFF) ? ovr_left_q : ovr_set_q;

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // every word not in the map answers all ones
  always @* begin
    rdata_d = `LIO_UNMAPPED;
    if (reg_addr == `LIO_ADDR_CONTROL) begin
      rdata_d = ctrl_word;
    end else if (reg_addr == `LIO_ADDR_STAGE) begin
      rdata_d = stage_word;
    end else if (reg_addr == `LIO_ADDR_RESULTS) begin
      rdata_d = results_word;
    end else if (reg_addr == `LIO_ADDR_AGE_DH) begin
      rdata_d = age_dh_word;
    end else if (reg_addr == `LIO_ADDR_AGE_MS) begin
      rdata_d = age_ms_word;
    end else if (reg_addr == `LIO_ADDR_DWELL) begin
      rdata_d = dwell_seconds_q;
    end else if (reg_addr == `LIO_ADDR_OVR_MODE) begin
      rdata_d = mode_code(ovr_state_q);
    end else if (reg_addr == `LIO_ADDR_OVR_TIME) begin
      rdata_d = time_word;
    end else begin
      rdata_d = `LIO_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------------
  // answer registers
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0;
      wr_done_q <= 1'b0;
      wr_reject_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_rd && !reg_wr;
      if (reg_rd && !reg_wr)
        rd_data_q <= rdata_d;
      wr_done_q <= reg_wr;
      wr_reject_q <= reg_wr && reject_d;
    end
  end

endmodule // lio_regs

/* hw/lio_regs_defs.vh */
/*
  constants for the lighting inspection and override register bank:
  register indices, field positions, value codes, limits, reset values.
  assumes it is included by bare name from the design files under hw/.
*/
// Behaviour
// - stage reads 4 while beacon released from inhibit, awaiting alarm clear
// - stage reads 5 marker pretest, 6 marker inhibit, 7 marker restore
// - stage reads 8 forcing photodiode alarm, 9 releasing photodiode alarm
// - result bit 8 is 1 when beacons were tested in red night
// - result bits 9..11 flag beacon pretest, inhibit, restore failures
// - result bit 12 is 1 when marker tier was tested in red night
// - result bits 13..15 flag marker pretest, inhibit, restore failures
// - first age register holds days high byte, hours low byte since power up
// - second age register holds minutes high byte, seconds low byte
// - stage time register holds dwell seconds between inspection stages
// - stage time legal range is 30 to 7200 seconds inclusive
// - mode register reads 0 off, 1 day, 3 red night
// - mode register accepts 1 day, 3 red night, 4 cancel
// - duration legal range 1 to 65535 minutes; write sets duration
// - active override: duration register reads minutes remaining
// - inactive override: duration register reads last programmed duration
// - stage reads 0 inactive, 1 started, 2 beacon pretest, 3 beacon inhibit
// - control bit 3, read only, set once inspection completed with results
`ifndef LIO_REGS_DEFS_VH
`define LIO_REGS_DEFS_VH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define LIO_ADDR_CONTROL 8'h1e
`define LIO_ADDR_STAGE 8'h1f
`define LIO_ADDR_RESULTS 8'h20
`define LIO_ADDR_AGE_DH 8'h21
`define LIO_ADDR_AGE_MS 8'h22
`define LIO_ADDR_DWELL 8'h2c
`define LIO_ADDR_OVR_MODE 8'h3c
`define LIO_ADDR_OVR_TIME 8'h3d

// ----------------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------------
`define LIO_CTRL_RUNNING_BIT 0
`define LIO_CTRL_READY_BIT 3
`define LIO_RES_LSB 8
`define LIO_STAGE_W 4
`define LIO_STAGE_LAST 4'h9
`define LIO_UNMAPPED 16'hffff
`define LIO_MODE_OFF 16'h0000
`define LIO_MODE_DAY 16'h0001
`define LIO_MODE_NIGHT 16'h0003
`define LIO_MODE_CANCEL 16'h0004

// ----------------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------------
`define LIO_DWELL_MIN 16'h001e
`define LIO_DWELL_MAX 16'h1c20
`define LIO_DWELL_RST 16'h001e
`define LIO_OVR_TIME_MIN 16'h0001
`define LIO_OVR_TIME_RST 16'h003c
`define LIO_SEC_PER_MIN 6'h3b
`define LIO_MIN_PER_HOUR 8'h3b
`define LIO_HOUR_PER_DAY 8'h17
`define LIO_DAY_MAX 8'hff
`define LIO_CLK_HZ 20000000
`define LIO_SEC_IN_SEC 1

`endif

/* hw/lio_uptime.v */
/*
  time since power up: seconds, minutes, hours and days, plus a one
  cycle pulse at every whole second. assumes ref_clk at the rate given
  by CYC_PER_SEC and a synchronous active low reset at power up.
*/
`timescale 1ns/1ns
`include "lio_regs_defs.vh"

module lio_uptime #(
  parameter CYC_PER_SEC = `LIO_CLK_HZ * `LIO_SEC_IN_SEC
) (
  input wire ref_clk,
  input wire rst_n,
  output reg sec_tick_q,
  output reg [7:0] sec_q,
  output reg [7:0] min_q,
  output reg [7:0] hour_q,
  output reg [7:0] day_q
);

  reg [31:0] div_q;
  wire div_wrap;

  assign div_wrap = (div_q == CYC_PER_SEC - 1);

  // ----------------------------------------------------------------------
  // prescaler and calendar counters
  // ----------------------------------------------------------------------
  // days saturate rather than wrap so a long uptime never looks fresh
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      div_q <= 32'h0;
      sec_tick_q <= 1'b0;
      sec_q <= 8'h0;
      min_q <= 8'h0;
      hour_q <= 8'h0;
      day_q <= 8'h0;
    end else begin
      sec_tick_q <= div_wrap;
      div_q <= div_wrap ? 32'h0 : div_q + 32'h1;
      if (div_wrap) begin
        if (sec_q[5:0] != `LIO_SEC_PER_MIN) begin
          sec_q <= sec_q + 8'h1;
        end else begin
          sec_q <= 8'h0;
          if (min_q != `LIO_MIN_PER_HOUR) begin
            min_q <= min_q + 8'h1;
          end else begin
            min_q <= 8'h0;
            if (hour_q != `LIO_HOUR_PER_DAY) begin
              hour_q <= hour_q + 8'h1;
            end else begin
              hour_q <= 8'h0;
              if (day_q != `LIO_DAY_MAX)
                day_q <= day_q + 8'h1;
            end
          end
        end
      end
    end
  end

endmodule // lio_uptime
